// ---- hw/fsb_params.svh ----
// offsets, field positions, reset values and timing counts of the flash status block
`ifndef FSB_PARAMS_SVH
`define FSB_PARAMS_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define FSB_OFF_CTRL      6'h00
`define FSB_OFF_WDATA     6'h04
`define FSB_OFF_ARRAY     6'h08
`define FSB_OFF_SUSP      6'h0C
`define FSB_OFF_CFG       6'h10
`define FSB_OFF_STATUS    6'h14
`define FSB_OFF_IRQ_STAT  6'h18
`define FSB_OFF_IRQ_CLR   6'h1C
`define FSB_OFF_IRQ_EN    6'h20
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FSB_CTRL_START    0
`define FSB_CTRL_DONE     1
`define FSB_CTRL_SYNC     2
`define FSB_CTRL_ESUSP    3
`define FSB_CFG_RTS       18
`define FSB_CFG_WSC_LO    12
`define FSB_IRQ_DONE      0
`define FSB_IRQ_XING      1
`define FSB_IRQ_RSVD      2
`define FSB_IRQ_PROT      3
`define FSB_IRQ_W         4
`define FSB_SECT_LSB      15
// ----------------------------------------------------------------------
// reset values and latency figures
// ----------------------------------------------------------------------
`define FSB_RST_WSC       3'h5
`define FSB_LAT_BASE      4'h2
`define FSB_XING_EXTRA    4'h2
`define FSB_WSC_MAX       3'h5
`define FSB_GRP_LAST      6'h3F
`define FSB_GRP_PREV      6'h3E
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FSB_CLK_PERIOD_PS 5000
`define FSB_T_RSP_NS      4000
`define FSB_RSP_CYC       ((`FSB_T_RSP_NS * 1000 + `FSB_CLK_PERIOD_PS - 1) / `FSB_CLK_PERIOD_PS)
`endif

// ---- hw/fsb_pkg.sv ----
// types shared by the flash status block modules
package fsb_pkg;
  typedef logic [21:0] fsb_addr_t;
  typedef logic [15:0] fsb_word_t;
  typedef enum logic [1:0] {
    BST_IDLE = 2'b00,
    BST_WAIT = 2'b01,
    BST_DATA = 2'b10
  } fsb_burst_t;
endpackage

// ---- hw/fsb_core_if.sv ----
// interface between the burst engine and its status and latency helpers
`timescale 1ns/1ps
interface fsb_core_if;
  import fsb_pkg::*;
  logic      readPulse;
  fsb_addr_t readAddr;
  logic      busy;
  logic      eraseSusp;
  logic [6:0] suspSector;
  fsb_word_t writtenData;
  fsb_word_t arrayData;
  fsb_word_t dataWord;
  logic      genToggle;
  logic [2:0] waitCode;
  fsb_addr_t startAddr;
  logic [3:0] initWait;
  logic      reservedCode;
  logic      skipFirst;
  modport statgen (input readPulse, readAddr, busy, eraseSusp, suspSector, writtenData,
                   arrayData, output dataWord, genToggle);
  modport latcalc (input waitCode, startAddr, output initWait, reservedCode, skipFirst);
  modport core    (output readPulse, readAddr, busy, eraseSusp, suspSector, writtenData,
                   arrayData, waitCode, startAddr,
                   input dataWord, genToggle, initWait, reservedCode, skipFirst);
endinterface

// ---- hw/fsb_status_gen.sv ----
// polling and toggle status word generator
`timescale 1ns/1ps
`include "fsb_params.svh"
module fsb_status_gen (
  input wire logic    clk,
  input wire logic    reset_n,
  fsb_core_if.statgen core
);
  import fsb_pkg::*;
  logic genTog_q;
  logic susTog_q;
  logic genTog_d;
  logic susTog_d;
  // ----------------------------------------------------------------------
  // sector match and toggle next values
  // ----------------------------------------------------------------------
  wire inSect     = core.readAddr[21:`FSB_SECT_LSB] == core.suspSector;
  wire susRead    = core.eraseSusp & inSect;
  wire viewStatus = core.busy | susRead;
  assign genTog_d = genTog_q ^ (core.readPulse & core.busy); // RQ3
  assign susTog_d = susTog_q ^ (core.readPulse & susRead);   // RQ6
  // toggle flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      genTog_q <= 1'b0;
      susTog_q <= 1'b0;
    end else begin
      genTog_q <= genTog_d;
      susTog_q <= susTog_d;
    end
  end
  // status word while busy or reading the suspended sector, true data otherwise
  assign core.dataWord = viewStatus ?
    {core.writtenData[15:8], ~core.writtenData[7] & core.busy, genTog_q,
     core.writtenData[5:3], susTog_q, core.writtenData[1:0]} :
    core.arrayData; // RQ2
  assign core.genToggle = genTog_q;
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_poll_inverse: assert property (core.busy |-> core.dataWord[7] == ~core.writtenData[7]) // RQ2
    else $error("polling bit not inverted while busy");
  a_true_data: assert property (!viewStatus |-> core.dataWord == core.arrayData) // RQ2
    else $error("true data not returned after completion");
  a_toggle_busy: assert property (core.readPulse && core.busy |=> genTog_q != $past(genTog_q)) // RQ3
    else $error("general toggle did not flip on status read");
  a_toggle_stop: assert property (!core.busy |=> $stable(genTog_q)) // RQ3
    else $error("general toggle moved after completion");
  a_susp_sector: assert property (!(core.eraseSusp && inSect) |=> $stable(susTog_q)) // RQ6
    else $error("suspend toggle moved outside suspended sector");
endmodule

// ---- hw/fsb_latency_calc.sv ----
// wait-state decode and boundary latency for synchronous bursts
`timescale 1ns/1ps
`include "fsb_params.svh"
module fsb_latency_calc (
  fsb_core_if.latcalc lat
);
  import fsb_pkg::*;
  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire       rsvd    = lat.waitCode > `FSB_WSC_MAX;           // RQ13
  wire [2:0] useCode = rsvd ? `FSB_WSC_MAX : lat.waitCode;    // reserved clamps to maximum
  wire [3:0] base    = {1'b0, useCode} + `FSB_LAT_BASE;       // RQ13
  wire       atZero  = lat.startAddr == '0;                   // RQ11
  assign lat.initWait     = atZero ? base + `FSB_XING_EXTRA : base; // RQ11
  assign lat.reservedCode = rsvd;
  assign lat.skipFirst    = (lat.startAddr[5:0] == `FSB_GRP_LAST) ||
                            (lat.startAddr[5:0] == `FSB_GRP_PREV); // RQ12
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  always_comb begin
    a_wait_decode: assert (rsvd || atZero || lat.initWait == {1'b0, lat.waitCode} + 4'h2) // RQ13
      else $error("wait code decoded to wrong total latency");
    a_zero_extra: assert (!atZero || lat.initWait == base + 4'h2) // RQ11
      else $error("start at zero missed extra latency");
    a_reserved_code: assert (lat.waitCode[2:1] != 2'b11 || lat.reservedCode) // RQ13
      else $error("reserved wait code not flagged");
  end
endmodule

// ---- hw/fsb_top.sv ----
// flash status polling, ready timing and burst latency engine with Avalon-MM registers
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "fsb_params.svh"
// Summary of operation
// [RQ1] host reads status twice to judge progress
// [RQ2] polling bit inverted while busy, true after
// [RQ3] toggle bits flip per read while busy
// [RQ4] async mode holds ready low while busy
// [RQ5] ready with data or one clock ahead
// [RQ6] suspend toggle flips only in suspended sector
// [RQ7] host may cycle output or chip enable
// [RQ8] raised reset held 4 us before unprotect
// [RQ9] raised reset held 4 us after ready
// [RQ10] address bit 6 picks protect or unprotect
// [RQ11] boundary every 64 words, zero included
// [RQ12] two extra cycles unless start 3E/3F
// [RQ13] wait code gives N plus two cycles
// [RQ14] host may read idle bank meanwhile
// [RQ15] sync status reads use burst latency
module fsb_top (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire fsb_pkg::fsb_addr_t pinAddr,
  input  wire logic              flashClk,
  input  wire logic              avdN,
  input  wire logic              ceN,
  input  wire logic              oeN,
  input  wire logic              vidLevel,
  output fsb_pkg::fsb_word_t     dqOut,
  output logic                   dqOeN,
  output logic                   rdy,
  output logic                   irq
);
  import fsb_pkg::*;
  localparam int PINW = 27;
  localparam logic [9:0] RSP_CYC = 10'(`FSB_RSP_CYC);

  fsb_core_if core ();
  fsb_status_gen u_stat (
    .clk     (clk),
    .reset_n (reset_n),
    .core    (core)
  );
  fsb_latency_calc u_lat (
    .lat (core)
  );
  // ----------------------------------------------------------------------
  // pin synchronisers, three stages with agreement filter
  // ----------------------------------------------------------------------
  logic [PINW-1:0] pinS1_q, pinS2_q, pinS3_q, pinF_q, pinP_q;
  wire  [PINW-1:0] pinRaw = {vidLevel, oeN, ceN, avdN, flashClk, pinAddr};
  wire  [PINW-1:0] pinF_d = (pinS2_q & pinS3_q) | (pinF_q & (pinS2_q ^ pinS3_q));
  // sync chain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinS1_q <= 27'h3800000; // strobes idle high, clock and raised level low
      pinS2_q <= 27'h3800000;
      pinS3_q <= 27'h3800000;
      pinF_q  <= 27'h3800000;
      pinP_q  <= 27'h3800000;
    end else begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinF_q  <= pinF_d;
      pinP_q  <= pinF_q;
    end
  end
  // filtered pins and edges
  wire fsb_addr_t sAddr = pinF_q[21:0];
  wire sClk  = pinF_q[22];
  wire sAvdN = pinF_q[23];
  wire sCeN  = pinF_q[24];
  wire sOeN  = pinF_q[25];
  wire sVid  = pinF_q[26];
  wire fclkRise = sClk & ~pinP_q[22];
  wire avdFall  = ~sAvdN & pinP_q[23];
  wire ceFall   = ~sCeN & pinP_q[24];
  wire oeFall   = ~sOeN & pinP_q[25];
  wire readOn   = ~sCeN & ~sOeN;
  // ----------------------------------------------------------------------
  // Avalon-MM slave, one wait cycle per access
  // ----------------------------------------------------------------------
  logic        waitReq_q;
  logic [31:0] rdData_q;
  logic        busy_q, sync_q, esusp_q, rts_q;
  logic [2:0]  wsc_q;
  fsb_word_t   wdata_q, array_q;
  logic [6:0]  susp_q;
  logic [`FSB_IRQ_W-1:0] irqStat_q, irqEn_q;
  logic        protValid_q, protDir_q, irq_q;
  wire req    = avs_read | avs_write;
  wire reqNew = req & waitReq_q;
  wire wrEn   = avs_write & ~waitReq_q;
  wire wrCtrl = wrEn && avs_address == `FSB_OFF_CTRL;
  wire wrWdat = wrEn && avs_address == `FSB_OFF_WDATA;
  wire wrArr  = wrEn && avs_address == `FSB_OFF_ARRAY;
  wire wrSusp = wrEn && avs_address == `FSB_OFF_SUSP;
  wire wrCfg  = wrEn && avs_address == `FSB_OFF_CFG;
  wire wrClr  = wrEn && avs_address == `FSB_OFF_IRQ_CLR;
  wire wrIen  = wrEn && avs_address == `FSB_OFF_IRQ_EN;
  logic unprotReady;
  wire [31:0] ctrlView = {28'h0, esusp_q, sync_q, 1'b0, busy_q};
  wire [31:0] cfgView  = {13'h0, rts_q, 3'h0, wsc_q, 12'h0};
  wire [31:0] statView = {28'h0, protDir_q, protValid_q, unprotReady, busy_q};
  wire [31:0] rdMux =
    (avs_address == `FSB_OFF_CTRL)     ? ctrlView :
    (avs_address == `FSB_OFF_WDATA)    ? {16'h0, wdata_q} :
    (avs_address == `FSB_OFF_ARRAY)    ? {16'h0, array_q} :
    (avs_address == `FSB_OFF_SUSP)     ? {25'h0, susp_q} :
    (avs_address == `FSB_OFF_CFG)      ? cfgView :
    (avs_address == `FSB_OFF_STATUS)   ? statView :
    (avs_address == `FSB_OFF_IRQ_STAT) ? {28'h0, irqStat_q} :
    (avs_address == `FSB_OFF_IRQ_EN)   ? {28'h0, irqEn_q} : 32'h0;
  // bus handshake and read data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitReq_q <= 1'b1;
      rdData_q  <= 32'h0;
    end else begin
      waitReq_q <= ~reqNew;
      if (reqNew && avs_read) rdData_q <= rdMux;
    end
  end
  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  wire busy_d = (wrCtrl & avs_writedata[`FSB_CTRL_START]) |
                (busy_q & ~(wrCtrl & avs_writedata[`FSB_CTRL_DONE]));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      sync_q <= 1'b0;
      esusp_q <= 1'b0;
      rts_q <= 1'b0;
      wsc_q <= `FSB_RST_WSC;
      wdata_q <= 16'h0;
      array_q <= 16'h0;
      susp_q <= 7'h0;
      irqEn_q <= 4'h0;
    end else begin
      busy_q <= busy_d;
      if (wrCtrl) sync_q <= avs_writedata[`FSB_CTRL_SYNC];
      if (wrCtrl) esusp_q <= avs_writedata[`FSB_CTRL_ESUSP];
      if (wrCfg) rts_q <= avs_writedata[`FSB_CFG_RTS];
      if (wrCfg) wsc_q <= avs_writedata[`FSB_CFG_WSC_LO +: 3];
      if (wrWdat) wdata_q <= avs_writedata[15:0];
      if (wrArr) array_q <= avs_writedata[15:0];
      if (wrSusp) susp_q <= avs_writedata[6:0];
      if (wrIen) irqEn_q <= avs_writedata[`FSB_IRQ_W-1:0];
    end
  end
  // ----------------------------------------------------------------------
  // temporary unprotect: raised reset must stand before protect commands
  // ----------------------------------------------------------------------
  logic [9:0] vidCnt_q;
  wire  [9:0] vidCnt_d = !sVid ? 10'h0 : (unprotReady ? vidCnt_q : vidCnt_q + 10'h1); // RQ8
  assign unprotReady = vidCnt_q == RSP_CYC;
  wire protSel = avdFall & unprotReady & sAddr[1] & ~sAddr[0]; // RQ10
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vidCnt_q <= 10'h0;
      protValid_q <= 1'b0;
      protDir_q <= 1'b0;
    end else begin
      vidCnt_q <= vidCnt_d;
      protValid_q <= protSel | (protValid_q & sVid);
      if (protSel) protDir_q <= sAddr[6]; // RQ10
    end
  end
  // ----------------------------------------------------------------------
  // synchronous burst engine
  // ----------------------------------------------------------------------
  fsb_burst_t bst_q, bst_d;
  fsb_addr_t  bAddr_q, bAddr_d;
  logic [3:0] wCnt_q, wCnt_d;
  logic       skip_q, skip_d, evXing, evRsvd, burstPulse;
  wire startBurst = sync_q & fclkRise & ~sAvdN & ~sCeN;
  wire atEdge     = bAddr_q[5:0] == `FSB_GRP_LAST;
  wire xingNow    = atEdge & ~skip_q; // RQ11
  // next state
  always_comb begin
    bst_d = bst_q;
    bAddr_d = bAddr_q;
    wCnt_d = wCnt_q;
    skip_d = skip_q;
    evXing = 1'b0;
    evRsvd = 1'b0;
    burstPulse = 1'b0;
    if (sCeN || !sync_q) begin
      bst_d = BST_IDLE;
    end else if (startBurst) begin
      bst_d = BST_WAIT;
      bAddr_d = sAddr;
      wCnt_d = core.initWait; // RQ13
      skip_d = core.skipFirst; // RQ12
      evRsvd = core.reservedCode;
    end else if (fclkRise) begin
      unique case (bst_q)
        BST_IDLE: bst_d = BST_IDLE;
        BST_WAIT: begin
          if (wCnt_q > 4'h1) begin
            wCnt_d = wCnt_q - 4'h1;
          end else begin
            bst_d = BST_DATA;
            burstPulse = 1'b1; // RQ15
          end
        end
        BST_DATA: begin
          bAddr_d = bAddr_q + 22'h1;
          if (atEdge) skip_d = 1'b0;
          if (xingNow) begin
            bst_d = BST_WAIT;
            wCnt_d = `FSB_XING_EXTRA; // RQ12
            evXing = 1'b1;
          end else begin
            burstPulse = 1'b1;
          end
        end
        default: bst_d = BST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bst_q <= BST_IDLE;
      bAddr_q <= 22'h0;
      wCnt_q <= 4'h0;
      skip_q <= 1'b0;
    end else begin
      bst_q <= bst_d;
      bAddr_q <= bAddr_d;
      wCnt_q <= wCnt_d;
      skip_q <= skip_d;
    end
  end
  // ----------------------------------------------------------------------
  // status helper hookup and data pins
  // ----------------------------------------------------------------------
  wire asyncPulse = ~sync_q & ((oeFall & ~sCeN) | (ceFall & ~sOeN)); // RQ7
  assign core.readPulse   = asyncPulse | burstPulse; // RQ3
  assign core.readAddr    = sync_q ? bAddr_q : sAddr;
  assign core.busy        = busy_q;
  assign core.eraseSusp   = esusp_q;
  assign core.suspSector  = susp_q;
  assign core.writtenData = wdata_q;
  assign core.arrayData   = array_q;
  assign core.waitCode    = wsc_q;
  assign core.startAddr   = sAddr;
  wire dataPhase = bst_q == BST_DATA;
  wire aheadOk   = (bst_q == BST_WAIT && wCnt_q == 4'h1) || (dataPhase && !xingNow);
  wire syncRdy   = rts_q ? aheadOk : dataPhase; // RQ5
  wire rdy_d     = sync_q ? syncRdy : ~busy_q; // RQ4
  fsb_word_t dq_d;
  assign dq_d = (sync_q ? burstPulse : readOn) ? core.dataWord : dqOut; // RQ15
  wire dqOeN_d = ~(readOn & (~sync_q | dataPhase));
  // ----------------------------------------------------------------------
  // interrupt status, set wins over clear
  // ----------------------------------------------------------------------
  wire evDone = busy_q & wrCtrl & avs_writedata[`FSB_CTRL_DONE];
  wire [`FSB_IRQ_W-1:0] evVec  = {protSel, evRsvd, evXing, evDone};
  wire [`FSB_IRQ_W-1:0] clrVec = wrClr ? avs_writedata[`FSB_IRQ_W-1:0] : 4'h0;
  wire [`FSB_IRQ_W-1:0] irqStat_d = (irqStat_q & ~clrVec) | evVec;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_q <= 4'h0;
      irq_q <= 1'b0;
      rdy <= 1'b0;
      dqOut <= 16'h0;
      dqOeN <= 1'b1;
    end else begin
      irqStat_q <= irqStat_d;
      irq_q <= |(irqStat_d & irqEn_q);
      rdy <= rdy_d;
      dqOut <= dq_d;
      dqOeN <= dqOeN_d;
    end
  end
  assign irq             = irq_q;
  assign avs_readdata    = rdData_q;
  assign avs_waitrequest = waitReq_q;
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_async_rdy_low: assert property (!sync_q && busy_q |=> !rdy) // RQ4
    else $error("ready high during async embedded operation");
  a_rdy_ahead: assert property (sync_q && rts_q && bst_q == BST_WAIT && wCnt_q == 4'h1 // RQ5
                                |=> rdy)
    else $error("ready not one clock ahead of data");
  a_rdy_with_data: assert property (sync_q && !rts_q && bst_q == BST_WAIT |=> !rdy) // RQ5
    else $error("ready before data with timing select clear");
  a_xing_extra: assert property (sync_q && !sCeN && !startBurst && fclkRise // RQ12
                                 && dataPhase && xingNow
                                 |=> bst_q == BST_WAIT && wCnt_q == 4'h2)
    else $error("boundary crossing did not add two cycles");
  a_skip_start: assert property (startBurst && sAddr[5:1] == 5'h1F |=> skip_q) // RQ12
    else $error("start at 3E or 3F still pays crossing");
  a_burst_word: assert property (burstPulse && readOn |=> dqOut == $past(core.dataWord)) // RQ15
    else $error("burst word not driven from status path");
  a_protect_dir: assert property (protSel |=> protValid_q && protDir_q == $past(sAddr[6])) // RQ10
    else $error("protect direction not captured");
  a_irq_sticky: assert property (evXing |=> irqStat_q[`FSB_IRQ_XING]) // RQ11
    else $error("crossing event lost");
  c_xing: cover property (evXing);
  c_async_status: cover property (asyncPulse && busy_q);
  c_protect: cover property (protSel);
  c_irq: cover property (irq);
endmodule

// ---- testbench/fsb_host_model.sv ----
// host controller model driving the flash pins of the status block
`timescale 1ns/1ps
module fsb_host_model (
  input  wire logic               clk,
  input  wire fsb_pkg::fsb_word_t dqOut,
  input  wire logic               dqOeN,
  input  wire logic               rdy,
  output fsb_pkg::fsb_addr_t      pinAddr,
  output logic                    flashClk,
  output logic                    avdN,
  output logic                    ceN,
  output logic                    oeN,
  output logic                    vidLevel
);
  import fsb_pkg::*;
  // pins idle: deselected, burst clock parked low
  initial begin
    pinAddr = '0;
    {flashClk, avdN, ceN, oeN, vidLevel} = 5'b01110;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // async status read; deselect after it so the next read toggles again
  task automatic readWord(input fsb_addr_t a, output fsb_word_t w);
    @(posedge clk);
    pinAddr <= a;
    ceN <= 1'b0;
    oeN <= 1'b0;
    idle(12);
    w = dqOeN ? ~dqOut : dqOut; // released bus reads back inverted
    oeN <= 1'b1;
    ceN <= 1'b1;
    idle(10);
  endtask
  // one burst clock level, slow enough for the pin filter
  task automatic tick(input logic lvl);
    @(posedge clk);
    flashClk <= lvl;
    idle(7);
  endtask
  // latch at rise zero, then ten rises; ready sampled before each next rise
  task automatic burst(input fsb_addr_t a, output logic [9:0] v);
    @(posedge clk);
    pinAddr <= a;
    avdN <= 1'b0;
    ceN <= 1'b0;
    oeN <= 1'b0;
    idle(8);
    tick(1'b1);
    avdN <= 1'b1;
    tick(1'b0);
    for (int i = 0; i < 10; i++) begin
      tick(1'b1);
      tick(1'b0);
      v[i] = rdy;
    end
    ceN <= 1'b1;
    oeN <= 1'b1;
    idle(12);
  endtask
  // raised reset level, held past setup and past ready high
  task automatic setVid(input logic lvl);
    @(posedge clk);
    vidLevel <= lvl;
    idle(810);
  endtask
  // address strobe carrying the protect direction
  task automatic protect(input fsb_addr_t a);
    @(posedge clk);
    pinAddr <= a;
    idle(8);
    avdN <= 1'b0;
    idle(8);
    avdN <= 1'b1;
    idle(8);
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench for the flash status block
`timescale 1ns/1ps
`include "fsb_params.svh"
module tb_top;
  import fsb_pkg::*;
  typedef struct {logic [5:0] a; logic wr; logic [31:0] wd; logic [31:0] ex;} fsb_row_t;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [5:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, flashClk, avdN, ceN, oeN, vidLevel, dqOeN, rdy, irq;
  fsb_addr_t   pinAddr;
  fsb_word_t   dqOut, w1, w2;
  logic [9:0]  v, ex10;
  int          failures = 0;
  int          checked = 0;
  int          w;
  // register reset values and access kinds
  fsb_row_t    rows [8] = '{
    '{`FSB_OFF_CFG, 1'b0, 32'h0, 32'h0000_5000},
    '{`FSB_OFF_STATUS, 1'b0, 32'h0, 32'h0},
    '{`FSB_OFF_IRQ_STAT, 1'b0, 32'h0, 32'h0},
    '{`FSB_OFF_STATUS, 1'b1, 32'hF, 32'h0},
    '{`FSB_OFF_IRQ_EN, 1'b1, 32'hF, 32'hF},
    '{`FSB_OFF_IRQ_CLR, 1'b1, 32'hF, 32'h0},
    '{6'h3C, 1'b1, 32'hFFFF_FFFF, 32'h0},
    '{`FSB_OFF_CTRL, 1'b0, 32'h0, 32'h0}};
  always #2.5 clk = ~clk;
  fsb_top dut_u (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pinAddr(pinAddr),
    .flashClk(flashClk), .avdN(avdN), .ceN(ceN), .oeN(oeN), .vidLevel(vidLevel),
    .dqOut(dqOut), .dqOeN(dqOeN), .rdy(rdy), .irq(irq));
  fsb_host_model host_u (.clk(clk), .dqOut(dqOut), .dqOeN(dqOeN), .rdy(rdy), .pinAddr(pinAddr),
    .flashClk(flashClk), .avdN(avdN), .ceN(ceN), .oeN(oeN), .vidLevel(vidLevel));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one bus access held until waitrequest is seen low, bounded
  task automatic busCycle(input logic [5:0] a, input logic wr, input logic [31:0] wd,
                          output logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic busWrite(input logic [5:0] a, input logic [31:0] wd);
    logic [31:0] d;
    busCycle(a, 1'b1, wd, d);
  endtask
  task automatic busRead(input logic [5:0] a, output logic [31:0] d);
    busCycle(a, 1'b0, 32'h0, d);
  endtask
  task automatic chkReg(input logic [31:0] got, input logic [31:0] ex);
    checked++;
    if (got !== ex) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, ex);
    end
  endtask
  task automatic chkPin(input logic [15:0] got, input logic [15:0] ex);
    checked++;
    if (got !== ex) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, ex);
    end
  endtask
  // main sequence: table, polling, bursts, protect
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) busWrite(rows[i].a, rows[i].wd);
      busRead(rows[i].a, rd);
      chkReg(rd, rows[i].ex);
    end
    busWrite(`FSB_OFF_IRQ_EN, 32'h1);
    busWrite(`FSB_OFF_WDATA, 32'h0000_00A5);
    busWrite(`FSB_OFF_ARRAY, 32'h0000_1234);
    busWrite(`FSB_OFF_SUSP, 32'h1);
    busWrite(`FSB_OFF_CTRL, 32'h1);
    host_u.readWord(22'h000100, w1);
    host_u.readWord(22'h000100, w2);
    chkPin({15'h0, rdy}, 16'h0);
    chkPin(w1 & 16'hFFBB, 16'h0021);
    chkPin(w1 ^ w2, 16'h0040);
    busWrite(`FSB_OFF_CTRL, 32'h9);
    host_u.readWord(22'h008000, w1);
    host_u.readWord(22'h008000, w2);
    chkPin(w1 ^ w2, 16'h0044);
    busWrite(`FSB_OFF_CTRL, 32'h2);
    host_u.readWord(22'h000100, w1);
    host_u.readWord(22'h000100, w2);
    chkPin(w1, 16'h1234);
    chkPin(w2, 16'h1234);
    chkPin({14'h0, irq, rdy}, 16'h0003);
    busWrite(`FSB_OFF_IRQ_CLR, 32'h1);
    busRead(`FSB_OFF_IRQ_STAT, rd);
    chkReg(rd, 32'h0);
    chkPin({15'h0, irq}, 16'h0);
    // every wait code with both ready timings, start away from a boundary
    busWrite(`FSB_OFF_CTRL, 32'h4);
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 8; c++) begin
        w = ((c > 5) ? 5 : c) + 2;
        ex10 = ~((10'h1 << (w - 1)) - 10'h1);
        if (r == 1) ex10[w - 2] = 1'b1;
        busWrite(`FSB_OFF_CFG, (32'(r) << 18) | (32'(c) << 12));
        host_u.burst(22'h000010, v);
        chkPin({6'h0, v}, {6'h0, ex10});
      end
    end
    busWrite(`FSB_OFF_CFG, 32'h0);
    host_u.burst(22'h000000, v);
    chkPin({6'h0, v}, 16'h03F8);
    host_u.burst(22'h00003C, v);
    chkPin({6'h0, v}, 16'h039E);
    host_u.burst(22'h00007E, v);
    chkPin({6'h0, v}, 16'h03FE);
    busRead(`FSB_OFF_IRQ_STAT, rd);
    chkReg(rd, 32'h6);
    chkPin({15'h0, irq}, 16'h0);
    // temporary unprotect and direction capture
    busWrite(`FSB_OFF_CTRL, 32'h0);
    host_u.setVid(1'b1);
    busRead(`FSB_OFF_STATUS, rd);
    chkReg(rd, 32'h2);
    host_u.protect(22'h000042);
    busRead(`FSB_OFF_STATUS, rd);
    chkReg(rd, 32'hE);
    host_u.protect(22'h000002);
    busRead(`FSB_OFF_STATUS, rd);
    chkReg(rd, 32'h6);
    host_u.setVid(1'b0);
    busRead(`FSB_OFF_STATUS, rd);
    chkReg(rd, 32'h0);
    // mid-run reset: registers and outputs fall back to their idle values
    busWrite(`FSB_OFF_CFG, 32'h0004_2000);
    busRead(`FSB_OFF_CFG, rd);
    chkReg(rd, 32'h0004_2000);
    reset_n <= 1'b0;
    @(posedge clk);
    chkPin({12'h0, avs_waitrequest, dqOeN, rdy, irq}, 16'h000C);
    chkReg(avs_readdata, 32'h0);
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chkPin({15'h0, rdy}, 16'h0001);
    busRead(`FSB_OFF_CFG, rd);
    chkReg(rd, 32'h0000_5000);
    end_of_test();
  end
endmodule
